/* File: rtl/pusss_pkg.sv */
// Package with constants and types for the power-up soft-start sequencer
package pusss_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int OSC_FREQ_KHZ        = 600;
    localparam int SETTLE_DELAY_US     = 6800;
    localparam int SAMPLE_MAX_US       = 3400;
    localparam int SOFTSTART_US        = 6800;
    localparam int SETTLE_CYCLES       = (SETTLE_DELAY_US * OSC_FREQ_KHZ) / 1000;
    localparam int SAMPLE_MAX_CYCLES   = (SAMPLE_MAX_US * OSC_FREQ_KHZ) / 1000;
    localparam int SOFTSTART_CYCLES    = (SOFTSTART_US * OSC_FREQ_KHZ) / 1000;
    localparam int RAMP_STEPS          = 64;
    localparam int STEP_CYCLES         = SOFTSTART_CYCLES / RAMP_STEPS;
    localparam int EA_INIT_STEPS       = 2;
    localparam int DUMMY_SOFTSTARTS    = 2;
    localparam int CNT_W               = 16;
    localparam int TRIP_W              = 8;
    localparam int RAMP_W              = 7;

    // Ramp code at which the reference equals the final value
    localparam logic [RAMP_W-1:0] RAMP_FINAL = 7'h40;
    localparam logic [RAMP_W-1:0] RAMP_ZERO  = 7'h00;
    localparam logic [TRIP_W-1:0] TRIP_ZERO  = 8'h00;

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_RESET   = 7'h01,
        ST_WAIT_EN = 7'h02,
        ST_SETTLE  = 7'h04,
        ST_SAMPLE  = 7'h08,
        ST_SOFT    = 7'h10,
        ST_REG     = 7'h20,
        ST_HICCUP  = 7'h40
    } pusss_state_e;

    // Gate and amplifier controls toward the power stage
    typedef struct packed {
        logic hs_allow;
        logic ls_allow;
        logic ea_enable;
        logic trip_src_on;
    } pusss_drive_s;

endpackage

/* File: rtl/pusss_tick.sv */
// Divider that turns the system clock into oscillator-rate ticks
`timescale 1ns/10ps
module pusss_tick #(
    parameter int DIV = 166
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
);
    logic [15:0] cnt_reg;
    wire         wrap = (cnt_reg == 16'(DIV - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 16'h0000;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
            tick    <= wrap;
        end
    end
endmodule

/* File: rtl/pusss_seq.sv */
// Power-up soft-start sequencer: POR, enable, settle, trip sample, ramp, hiccup
//
// How it works
// - Bias POR rising starts sample sequence
// - Low enable pin postpones all initialization
// - Timing starts only above disable threshold
// - Fixed settle delay before trip sampling
// - Settle: low-side off, trip source on
// - Sample time grows with trip setting
// - Trip level held in counter for DAC
// - Sample done launches soft-start at once
// - Reference ramps zero to final value
// - Sixty-four equal steps, fixed rate
// - Error amp enabled after short init
// - Ramp reaching final ends soft-start
// - Prebias low: switches off until ramp passes
// - Prebias high: switches off until ramp ends
// - Ramp never waits for input supply
// - Enable toggle repeats full init, resample
// - Retries reuse stored trip level
// - Trip: shut off, two dummy ramps, retry
// - All delays counted in oscillator ticks
`timescale 1ns/10ps
module pusss_seq
    import pusss_pkg::*;
#(
    parameter int SETTLE_TICKS = SETTLE_CYCLES,
    parameter int SAMPLE_TICKS = SAMPLE_MAX_CYCLES,
    parameter int STEP_TICKS   = STEP_CYCLES,
    parameter int TICK_DIV     = 166
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              bias_por_ok,
    input  wire logic              en_above_dis,
    input  wire logic              trip_cmp_reached,
    input  wire logic              prebias_above_ramp,
    input  wire logic              overcurrent_guard,
    output pusss_pkg::pusss_drive_s drive,
    output logic [6:0]             ramp_code,
    output logic [7:0]             trip_dac,
    output logic                   softstart_done,
    output logic                   seq_state_onehot_valid
);
    import pusss_pkg::*;

    // ----------------------------------------------------------------
    // Oscillator tick
    // ----------------------------------------------------------------
    logic tick;

    pusss_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // ----------------------------------------------------------------
    // State and counters
    // ----------------------------------------------------------------
    pusss_state_e        state_reg;
    pusss_state_e        state_next;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    cnt_next;
    logic [RAMP_W-1:0]   ramp_reg;
    logic [RAMP_W-1:0]   ramp_next;
    logic [TRIP_W-1:0]   trip_reg;
    logic [TRIP_W-1:0]   trip_next;
    logic [1:0]          dummy_reg;
    logic [1:0]          dummy_next;
    logic                dummy_run_reg;
    logic                dummy_run_next;
    logic                switch_ok_reg;
    logic                switch_ok_next;

    wire cnt_hit_settle = (cnt_reg >= CNT_W'(SETTLE_TICKS - 1));
    wire cnt_hit_sample = (cnt_reg >= CNT_W'(SAMPLE_TICKS - 1));
    wire cnt_hit_step   = (cnt_reg >= CNT_W'(STEP_TICKS - 1));
    wire ramp_at_final  = (ramp_reg >= RAMP_FINAL);
    wire ea_ready       = (ramp_reg >= RAMP_W'(EA_INIT_STEPS));
    wire trip_full      = (trip_reg == {TRIP_W{1'b1}});
    wire step_now       = tick && cnt_hit_step;
    wire dummy_active   = (state_reg == ST_HICCUP) || dummy_run_reg;

    // Ramp counter advance; one code per step period
    function automatic logic [RAMP_W-1:0] ramp_inc(input logic [RAMP_W-1:0] r);
        ramp_inc = (r >= RAMP_FINAL) ? RAMP_FINAL : r + RAMP_W'(1);
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        ramp_next      = ramp_reg;
        trip_next      = trip_reg;
        dummy_next     = dummy_reg;
        dummy_run_next = dummy_run_reg;
        switch_ok_next = switch_ok_reg;
        case (state_reg)
            ST_RESET: begin
                trip_next      = TRIP_ZERO;
                ramp_next      = RAMP_ZERO;
                switch_ok_next = 1'b0;
                if (bias_por_ok) begin
                    state_next = ST_WAIT_EN;
                end
            end
            ST_WAIT_EN: begin
                cnt_next  = '0;
                ramp_next = RAMP_ZERO;
                // Nothing times until the pin has crossed the threshold
                if (en_above_dis) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // Old level cleared early so the comparator never sees it in sampling
                trip_next = TRIP_ZERO;
                if (tick) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
                if (tick && cnt_hit_settle) begin
                    cnt_next   = '0;
                    trip_next  = TRIP_ZERO;
                    state_next = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                // Counter climbs until the DAC matches the trip pin; a high
                // setting therefore takes longer, capped at the maximum time
                if (tick) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                    if (!trip_cmp_reached && !trip_full) begin
                        trip_next = trip_reg + TRIP_W'(1);
                    end
                end
                if (trip_cmp_reached || (tick && cnt_hit_sample) || trip_full) begin
                    cnt_next       = '0;
                    ramp_next      = RAMP_ZERO;
                    switch_ok_next = 1'b0;
                    state_next     = ST_SOFT;
                end
            end
            ST_SOFT: begin
                // Ramp is purely time based and never looks at the input rail
                if (tick) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
                if (step_now) begin
                    cnt_next  = '0;
                    ramp_next = ramp_inc(ramp_reg);
                end
                if (!prebias_above_ramp && !dummy_run_reg) begin
                    switch_ok_next = 1'b1;
                end
                if (step_now && ramp_at_final) begin
                    switch_ok_next = !dummy_run_reg;
                    state_next     = ST_REG;
                    if (dummy_run_reg) begin
                        state_next = ST_HICCUP;
                    end
                end
                if (overcurrent_guard && !dummy_run_reg) begin
                    switch_ok_next = 1'b0;
                    dummy_next     = 2'(DUMMY_SOFTSTARTS);
                    state_next     = ST_HICCUP;
                end
            end
            ST_REG: begin
                switch_ok_next = 1'b1;
                if (overcurrent_guard) begin
                    switch_ok_next = 1'b0;
                    dummy_next     = 2'(DUMMY_SOFTSTARTS);
                    state_next     = ST_HICCUP;
                end
            end
            ST_HICCUP: begin
                // Keeps the stored trip level; no resample on retries
                cnt_next       = '0;
                ramp_next      = RAMP_ZERO;
                switch_ok_next = 1'b0;
                state_next     = ST_SOFT;
                if (dummy_reg != 2'h0) begin
                    dummy_next     = dummy_reg - 2'h1;
                    dummy_run_next = 1'b1;
                end else begin
                    dummy_run_next = 1'b0;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
        // Enable pulled low after POR: full initialization again
        if (state_reg != ST_RESET && state_reg != ST_WAIT_EN && !en_above_dis) begin
            state_next     = ST_WAIT_EN;
            ramp_next      = RAMP_ZERO;
            switch_ok_next = 1'b0;
            dummy_run_next = 1'b0;
            dummy_next     = 2'h0;
        end
        if (!bias_por_ok) begin
            state_next     = ST_RESET;
            ramp_next      = RAMP_ZERO;
            trip_next      = TRIP_ZERO;
            switch_ok_next = 1'b0;
            dummy_run_next = 1'b0;
            dummy_next     = 2'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_RESET;
            cnt_reg       <= '0;
            ramp_reg      <= RAMP_ZERO;
            trip_reg      <= TRIP_ZERO;
            dummy_reg     <= 2'h0;
            dummy_run_reg <= 1'b0;
            switch_ok_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            ramp_reg      <= ramp_next;
            trip_reg      <= trip_next;
            dummy_reg     <= dummy_next;
            dummy_run_reg <= dummy_run_next;
            switch_ok_reg <= switch_ok_next;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    wire in_soft_or_reg = (state_reg == ST_SOFT) || (state_reg == ST_REG);
    wire sw_on          = in_soft_or_reg && switch_ok_reg && ea_ready && !dummy_active;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive                  <= '0;
            ramp_code              <= RAMP_ZERO;
            trip_dac               <= TRIP_ZERO;
            softstart_done         <= 1'b0;
            seq_state_onehot_valid <= 1'b0;
        end else begin
            drive.hs_allow         <= sw_on;
            drive.ls_allow         <= sw_on && (state_reg != ST_SETTLE);
            drive.ea_enable        <= in_soft_or_reg && ea_ready && !dummy_run_reg;
            drive.trip_src_on      <= (state_reg == ST_SETTLE) || (state_reg == ST_SAMPLE);
            ramp_code              <= ramp_reg;
            trip_dac               <= trip_reg;
            softstart_done         <= (state_reg == ST_REG);
            seq_state_onehot_valid <= $onehot(state_reg);
        end
    end

endmodule

/* File: verif/pusss_stage_model.sv */
// Model of the trip-set pin comparator and the pre-biased output
`timescale 1ns/10ps
module pusss_stage_model
    import pusss_pkg::*;
(
    input  wire logic [7:0]             trip_dac,
    input  wire logic [6:0]             ramp_code,
    input  wire pusss_pkg::pusss_drive_s drive,
    input  wire logic [7:0]             trip_level,
    input  wire logic [6:0]             pb_level,
    output logic                        trip_cmp_reached,
    output logic                        prebias_above_ramp
);
    // Pin voltage is reached once the DAC code climbs to the resistor level
    assign trip_cmp_reached   = (trip_dac >= trip_level);
    // Output keeps its charge until switching runs, then tracks the reference
    assign prebias_above_ramp = !drive.hs_allow && (pb_level > ramp_code);
endmodule

/* File: verif/pusss_seq_chk.sv */
// Port checker for the soft-start sequencer
`timescale 1ns/10ps
module pusss_seq_chk
    import pusss_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic                   bias_por_ok,
    input wire logic                   en_above_dis,
    input wire logic                   prebias_above_ramp,
    input wire logic                   overcurrent_guard,
    input wire pusss_pkg::pusss_drive_s drive,
    input wire logic [6:0]             ramp_code,
    input wire logic [7:0]             trip_dac,
    input wire logic                   softstart_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_bias_loss; (!bias_por_ok)[*3] |-> trip_dac == 8'h00 && !drive.hs_allow && !drive.ls_allow; endproperty
    a_bias_loss: assert property (p_bias_loss) else $error("bias loss kept trip level");
    property p_en_low; (!en_above_dis)[*3] |-> drive == 4'h0 && ramp_code == 7'h00 && !softstart_done; endproperty
    a_en_low: assert property (p_en_low) else $error("active while enable low");
    property p_trip_hold; $past(ramp_code) != 7'h00 && ramp_code != 7'h00 |-> $stable(trip_dac); endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip level moved in ramp");
    property p_step; ramp_code != $past(ramp_code) && ramp_code != 7'h00 |-> ramp_code == $past(ramp_code) + 7'h01; endproperty
    a_step: assert property (p_step) else $error("ramp step not one");
    property p_max; ramp_code <= RAMP_FINAL; endproperty
    a_max: assert property (p_max) else $error("ramp above final");
    property p_done; softstart_done |-> ramp_code == RAMP_FINAL; endproperty
    a_done: assert property (p_done) else $error("done below final");
    property p_src; drive.trip_src_on |-> !drive.ls_allow; endproperty
    a_src: assert property (p_src) else $error("low side on while sampling");
    property p_prebias; (prebias_above_ramp && !softstart_done)[*2] |-> !drive.hs_allow && !drive.ls_allow; endproperty
    a_prebias: assert property (p_prebias) else $error("switching under prebias");
    property p_oc; overcurrent_guard && softstart_done |-> ##[1:2] (!drive.hs_allow && !drive.ls_allow); endproperty
    a_oc: assert property (p_oc) else $error("no shutoff on overcurrent");
    c_done: cover property ($rose(softstart_done));
    c_oc: cover property (overcurrent_guard && softstart_done);
    c_src: cover property ($rose(drive.trip_src_on));
endmodule
bind pusss_seq pusss_seq_chk u_chk (.clk(clk), .rst_n(rst_n), .bias_por_ok(bias_por_ok), .en_above_dis(en_above_dis),
    .prebias_above_ramp(prebias_above_ramp), .overcurrent_guard(overcurrent_guard), .drive(drive),
    .ramp_code(ramp_code), .trip_dac(trip_dac), .softstart_done(softstart_done));

/* File: verif/pusss_seq_tb.sv */
// Self-checking bench for the soft-start sequencer
`timescale 1ns/10ps
module pusss_seq_tb;
    import pusss_pkg::*;
    // Short counts keep a full start near 350 clocks
    localparam int SET_T = 20;
    localparam int DIV   = 2;
    localparam int STEPC = 4;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         bias_por_ok = 1'b0;
    logic         en_above_dis = 1'b0;
    logic         overcurrent_guard = 1'b0;
    logic [7:0]   trip_level = 8'h01;
    logic [6:0]   pb_level = 7'h00;
    logic         trip_cmp_reached;
    logic         prebias_above_ramp;
    pusss_drive_s drive;
    logic [6:0]   ramp_code;
    logic [7:0]   trip_dac;
    logic         softstart_done;
    logic         onehot_ok;
    int           num_errors = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    always #5 clk = ~clk;
    pusss_seq #(.SETTLE_TICKS(SET_T), .SAMPLE_TICKS(10), .STEP_TICKS(2), .TICK_DIV(DIV)) DUT (
        .clk(clk), .rst_n(rst_n), .bias_por_ok(bias_por_ok), .en_above_dis(en_above_dis),
        .trip_cmp_reached(trip_cmp_reached), .prebias_above_ramp(prebias_above_ramp),
        .overcurrent_guard(overcurrent_guard), .drive(drive), .ramp_code(ramp_code), .trip_dac(trip_dac),
        .softstart_done(softstart_done), .seq_state_onehot_valid(onehot_ok));
    pusss_stage_model u_stage (.trip_dac(trip_dac), .ramp_code(ramp_code), .drive(drive), .trip_level(trip_level),
        .pb_level(pb_level), .trip_cmp_reached(trip_cmp_reached), .prebias_above_ramp(prebias_above_ramp));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic start_run(input logic [7:0] lvl, input logic [6:0] pb);
        int n;
        int bad;
        trip_level = lvl;
        pb_level = pb;
        en_above_dis = 1'b0;
        repeat (60) @(negedge clk);
        chk("idle_src", drive.trip_src_on, 1'b0);
        chk("idle_ramp", ramp_code, 7'h00);
        en_above_dis = 1'b1;
        repeat (2 * SET_T - 6) @(negedge clk);
        chk("settle_src", drive.trip_src_on, 1'b1);
        chk("settle_ls", drive.ls_allow, 1'b0);
        n = 0;
        while (ramp_code == 7'h00 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk("sample_len", n >= 2 * lvl && n <= 2 * lvl + 16, 1'b1);
        chk("sampled", trip_dac, lvl);
        n = 0;
        bad = 0;
        while (!softstart_done && n < 600) begin
            if (drive.hs_allow && ramp_code + 7'h01 < pb) bad++;
            @(negedge clk);
            n++;
        end
        chk("prebias_off", bad, 0);
        chk("ramp_len", n >= 64 * STEPC - 6 && n <= 64 * STEPC + 6, 1'b1);
        chk("done_ramp", ramp_code, RAMP_FINAL);
        chk("done_hs", drive.hs_allow, 1'b1);
        chk("done_ea", drive.ea_enable, 1'b1);
        chk("onehot", onehot_ok, 1'b1);
    endtask
    task automatic t_overcurrent();
        logic [7:0] kept;
        logic [6:0] last;
        int         n;
        int         starts;
        int         bad;
        kept = trip_dac;
        overcurrent_guard = 1'b1;
        @(negedge clk);
        overcurrent_guard = 1'b0;
        repeat (2) @(negedge clk);
        chk("oc_hs", drive.hs_allow, 1'b0);
        n = 0;
        starts = 0;
        bad = 0;
        last = ramp_code;
        while (!softstart_done && n < 3000) begin
            if (ramp_code == 7'h01 && last == 7'h00) starts++;
            if (starts < 3 && drive.hs_allow) bad++;
            last = ramp_code;
            @(negedge clk);
            n++;
        end
        chk("oc_starts", starts, 3);
        chk("oc_dummy_off", bad, 0);
        chk("oc_trip_kept", trip_dac, kept);
    endtask
    task automatic t_bias_loss();
        bias_por_ok = 1'b0;
        repeat (3) @(negedge clk);
        chk("bias_dac", trip_dac, 8'h00);
        chk("bias_drive", drive, 4'h0);
        bias_por_ok = 1'b1;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        bias_por_ok = 1'b1;
        start_run(8'h05, 7'h00);
        t_overcurrent();
        start_run(8'h09, 7'h7F);
        t_bias_loss();
        start_run(8'h03, 7'h14);
        start_run(8'h02, 7'h00);
        end_of_test();
    end
endmodule
